// ---- sdiaf_pkg.sv ----
// constants, tables and types shared by the descramble, align and output format block
package sdiaf_pkg;
    // wishbone register map, byte addresses
    localparam int WB_AW = 4;
    localparam logic [WB_AW-1:0] ADR_CTRL = 4'h0;
    localparam logic [WB_AW-1:0] ADR_STATUS = 4'h4;
    // control register fields
    localparam int CTRL_AUTO = 0;
    localparam int CTRL_VIDEO = 1;
    localparam int CTRL_ASI = 2;
    localparam int CTRL_WIDTH = 3;
    localparam int CTRL_RATE = 4;
    localparam int CTRL_W = 5;
    // auto rate, video processing and 20-bit width high after reset
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h0B;
    // status register fields
    localparam int ST_ALIGNED = 0;
    localparam int ST_RATE = 1;
    localparam int ST_TRS = 2;
    localparam int ST_WERR = 3;
    localparam int ST_SYNC = 4;
    // word framing
    localparam int WORD_BITS = 10;
    localparam int WIN_BITS = 3 * WORD_BITS;
    localparam logic [3:0] LAST_BIT = 4'h9;
    localparam logic [3:0] PCLK_FALL_BIT = 4'h4;
    localparam logic [3:0] XYZ_BITS = 4'hA;
    localparam int XYZ_H_BIT = 6;
    localparam int TRS_TIMEOUT_WORDS = 8192;
    // eight-bit form of the header only checks the upper eight bits
    localparam logic [7:0] TRS8_ONES = 8'hFF;
    localparam logic [7:0] TRS8_ZERO = 8'h00;
    localparam logic [9:0] TRS10_ONES = 10'h3FF;
    localparam logic [9:0] TRS10_ZERO = 10'h000;
    // comma of the asi sync character, both disparities
    localparam logic [6:0] COMMA_NEG = 7'h1F;
    localparam logic [6:0] COMMA_POS = 7'h60;
    localparam logic [5:0] K28_NEG = 6'h0F;
    localparam logic [5:0] K28_POS = 6'h30;
    localparam logic [4:0] K28_VAL = 5'h1C;
    localparam logic [3:0] K28_5_NEG = 4'hA;
    localparam logic [3:0] K28_5_POS = 4'h5;
    localparam logic [3:0] D7_ALT_NEG = 4'h7;
    localparam logic [3:0] D7_ALT_POS = 4'h8;
    // 5b/6b and 3b/4b codes for negative running disparity, first bit msb
    localparam logic [5:0] ASI_6B [0:31] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0] ASI_4B [0:7] = '{
        4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
    typedef enum logic [1:0] {
        SDIAF_THROUGH = 2'b00,
        SDIAF_VIDEO = 2'b01,
        SDIAF_ASI = 2'b10
    } sdiaf_mode_t;
endpackage

// ---- sdiaf_top.sv ----
// serial descrambler, trs/comma word aligner and 20-bit parallel output formatter
`timescale 1ns/1ps
module sdiaf_top #(
    parameter int unsigned TRS_TIMEOUT_WORDS = sdiaf_pkg::TRS_TIMEOUT_WORDS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [sdiaf_pkg::WB_AW-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    input wire logic reset_test_n_i,
    input wire logic detected_rate_flag_i,
    output logic [19:0] parallel_data_o,
    output logic parallel_data_oe_o,
    output logic output_clock_o,
    output logic output_clock_oe_o
);
    import sdiaf_pkg::*;

    if (TRS_TIMEOUT_WORDS < 2 || TRS_TIMEOUT_WORDS > 65535) begin : g_chk
        $error("TRS_TIMEOUT_WORDS must lie in 2..65535");
    end

    function automatic logic [3:0] popc(input logic [5:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 6; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    // {valid, k28, value}
    function automatic logic [6:0] dec6(input logic [5:0] c);
        logic [6:0] r;
        r = 7'h00;
        for (int i = 0; i < 32; i++) begin
            if (c == ASI_6B[i] || (c == ~ASI_6B[i] && (popc(ASI_6B[i]) != 4'h3 || i == 7))) begin
                r = {2'b10, 5'(i)};
            end
        end
        if (c == K28_NEG || c == K28_POS) begin
            r = {2'b11, K28_VAL};
        end
        return r;
    endfunction

    // {valid, value}
    function automatic logic [3:0] dec4(input logic [3:0] c);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < 8; i++) begin
            if (c == ASI_4B[i] || (c == ~ASI_4B[i] && (popc({2'b00, ASI_4B[i]}) != 4'h2 || i == 3))) begin
                r = {1'b1, 3'(i)};
            end
        end
        if (c == D7_ALT_NEG || c == D7_ALT_POS) begin
            r = 4'hF;
        end
        return r;
    endfunction

    // link pins pass two flops before any logic looks at them
    logic sclk_s1, sclk_s2, sclk_s3, sdat_s1, sdat_s2, sdat_s3, rtn_s1, rtn_s2;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
            {sdat_s1, sdat_s2, sdat_s3} <= 3'h0;
            {rtn_s1, rtn_s2} <= 2'h0;
        end else begin
            {sclk_s1, sclk_s2, sclk_s3} <= {serial_clk_i, sclk_s1, sclk_s2};
            {sdat_s1, sdat_s2, sdat_s3} <= {serial_data_i, sdat_s1, sdat_s2};
            {rtn_s1, rtn_s2} <= {reset_test_n_i, rtn_s1};
        end
    end

    // register bus
    logic [CTRL_W-1:0] ctrl, next_ctrl;
    logic [31:0] next_dat;
    logic next_ack;
    logic [4:0] status;
    always_comb begin
        next_ctrl = ctrl;
        next_dat = 32'h0000_0000;
        next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        if (next_ack) begin
            if (wb_adr_i == ADR_CTRL) begin
                next_dat = {27'h0, ctrl};
                if (wb_we_i && wb_sel_i[0]) begin
                    next_ctrl = wb_dat_i[CTRL_W-1:0];
                end
            end else if (wb_adr_i == ADR_STATUS) begin
                next_dat = {27'h0, status};
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= CTRL_RESET;
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            wb_dat_o <= next_dat;
            wb_ack_o <= next_ack;
        end
    end

    logic auto_rate_select, video_processing_select, asi_mode_select, bus_width_select;
    logic manual_rate_select, eff_rate;
    sdiaf_mode_t mode;
    assign auto_rate_select = ctrl[CTRL_AUTO];
    assign video_processing_select = ctrl[CTRL_VIDEO];
    assign asi_mode_select = ctrl[CTRL_ASI];
    assign bus_width_select = ctrl[CTRL_WIDTH];
    assign manual_rate_select = ctrl[CTRL_RATE];
    // rate only steers status here; the bus mapping does not depend on it
    assign eff_rate = auto_rate_select ? detected_rate_flag_i : manual_rate_select;
    always_comb begin
        if (asi_mode_select && !video_processing_select) begin
            mode = SDIAF_ASI;
        end else if (video_processing_select && !asi_mode_select) begin
            mode = SDIAF_VIDEO;
        end else begin
            mode = SDIAF_THROUGH;
        end
    end

    // bit path, aligner and formatter
    logic prev_raw, next_prev_raw, aligned, next_aligned, trs_seen, next_trs_seen;
    logic [8:0] scr, next_scr;
    logic [WIN_BITS-1:0] vsr, next_vsr;
    logic [3:0] bitcnt, next_bitcnt, trs_phase, next_trs_phase, cand_phase, next_cand_phase;
    logic [3:0] xyz_cnt, next_xyz_cnt;
    logic cand_valid, next_cand_valid, pair, next_pair, rd, next_rd;
    logic [9:0] hold, next_hold, word, code10;
    logic [15:0] idle_words, next_idle_words;
    logic [19:0] next_pdata;
    logic next_pclk, werr, next_werr, sync_seen, next_sync_seen;
    logic pend, next_pend;
    logic [19:0] pend_data, next_pend_data;
    logic bit_stb, raw, nrz, in_bit, trs_hit, comma_hit, realign, word_stb, emit;
    logic asi_word_error_pin, asi_sync_flag_pin;
    logic [6:0] d6;
    logic [3:0] d4, p6, p4;

    assign status = {sync_seen, werr, trs_seen, eff_rate, aligned};

    always_comb begin
        next_prev_raw = prev_raw;
        next_scr = scr;
        next_vsr = vsr;
        next_bitcnt = bitcnt;
        next_trs_phase = trs_phase;
        next_cand_phase = cand_phase;
        next_cand_valid = cand_valid;
        next_xyz_cnt = xyz_cnt;
        next_aligned = aligned;
        next_trs_seen = trs_seen;
        next_idle_words = idle_words;
        next_pair = pair;
        next_hold = hold;
        next_rd = rd;
        next_werr = werr;
        next_sync_seen = sync_seen;
        next_pdata = parallel_data_o;
        next_pclk = output_clock_o;
        next_pend = 1'b0;
        next_pend_data = pend_data;
        emit = 1'b0;
        realign = 1'b0;
        asi_word_error_pin = 1'b0;
        asi_sync_flag_pin = 1'b0;
        // value before the link clock edge, taken as the bit at that edge
        bit_stb = sclk_s2 & ~sclk_s3;
        raw = sdat_s3;
        nrz = raw ^ prev_raw;
        in_bit = (mode == SDIAF_VIDEO) ? (nrz ^ scr[3] ^ scr[8]) : raw;
        if (bit_stb) begin
            next_prev_raw = raw;
            next_scr = {scr[7:0], nrz};
            next_vsr = {in_bit, vsr[WIN_BITS-1:1]};
        end
        word = next_vsr[WIN_BITS-1:WIN_BITS-WORD_BITS];
        code10 = {<<{word}};
        trs_hit = bit_stb && mode == SDIAF_VIDEO && (
            (next_vsr[9:0] == TRS10_ONES && next_vsr[19:10] == TRS10_ZERO
                && next_vsr[29:20] == TRS10_ZERO)
            || (next_vsr[9:2] == TRS8_ONES && next_vsr[19:12] == TRS8_ZERO
                && next_vsr[29:22] == TRS8_ZERO));
        comma_hit = bit_stb && mode == SDIAF_ASI
            && (code10[9:3] == COMMA_NEG || code10[9:3] == COMMA_POS);
        d6 = dec6(code10[9:4]);
        d4 = dec4(code10[3:0]);
        p6 = popc(code10[9:4]);
        p4 = popc({2'b00, code10[3:0]});

        if (trs_hit) begin
            next_trs_seen = 1'b1;
            next_idle_words = 16'h0000;
            next_trs_phase = bitcnt;
            next_xyz_cnt = XYZ_BITS;
            if (!auto_rate_select) begin
                realign = 1'b1;
            end
        end else if (bit_stb && xyz_cnt != 4'h0) begin
            next_xyz_cnt = xyz_cnt - 4'h1;
            if (xyz_cnt == 4'h1 && auto_rate_select) begin
                if (!word[XYZ_H_BIT]) begin
                    next_cand_valid = 1'b1;
                    next_cand_phase = trs_phase;
                end else begin
                    // eav must follow a sav seen at the very same bit phase
                    next_cand_valid = 1'b0;
                    realign = cand_valid && cand_phase == trs_phase;
                end
            end
        end
        if (comma_hit) begin
            realign = 1'b1;
        end
        word_stb = bit_stb && (bitcnt == LAST_BIT || realign);
        if (bit_stb) begin
            next_bitcnt = (realign || bitcnt == LAST_BIT) ? 4'h0 : bitcnt + 4'h1;
        end
        if (realign) begin
            next_aligned = 1'b1;
            next_cand_valid = 1'b0;
        end
        if (word_stb && !trs_hit && idle_words != 16'hFFFF) begin
            next_idle_words = idle_words + 16'h0001;
        end
        if (mode != SDIAF_VIDEO && mode != SDIAF_ASI) begin
            next_aligned = 1'b0;
            next_trs_seen = 1'b0;
        end else if (mode == SDIAF_VIDEO && idle_words >= 16'(TRS_TIMEOUT_WORDS)) begin
            next_aligned = 1'b0;
            next_trs_seen = 1'b0;
        end

        if (word_stb) begin
            if (mode == SDIAF_ASI) begin
                asi_sync_flag_pin = d6[5] && (code10[3:0] == K28_5_NEG
                    || code10[3:0] == K28_5_POS);
                asi_word_error_pin = !d6[6] || !d4[3];
                if (p6 > 4'h3 || p4 > 4'h2) begin
                    asi_word_error_pin = asi_word_error_pin | rd;
                end
                if (p6 < 4'h3 || p4 < 4'h2) begin
                    asi_word_error_pin = asi_word_error_pin | ~rd;
                end
                if (p4 != 4'h2) begin
                    next_rd = p4 > 4'h2;
                end else if (p6 != 4'h3) begin
                    next_rd = p6 > 4'h3;
                end
                next_werr = asi_word_error_pin;
                next_sync_seen = asi_sync_flag_pin;
                // lower half held low, asi uses the 10-bit bus
                next_pdata = {asi_word_error_pin, asi_sync_flag_pin, d4[2:0], d6[4:0],
                    10'h000};
                emit = 1'b1;
            end else if (!bus_width_select) begin
                next_pdata = {word, 10'h000};
                emit = 1'b1;
            end else if (realign && !auto_rate_select) begin
                // the word under the trs detect is a chroma word
                next_hold = word;
                next_pair = 1'b1;
            end else if (realign) begin
                // the eav xyz word closes a pair, so chroma leads right after it
                next_pdata = {word, hold};
                next_pair = 1'b0;
                emit = 1'b1;
            end else if (!pair) begin
                next_hold = word;
                next_pair = 1'b1;
            end else begin
                next_pdata = {word, hold};
                next_pair = 1'b0;
                emit = 1'b1;
            end
        end
        if (emit && output_clock_o) begin
            // a word due while the clock is still high waits one cycle for a fresh rising edge
            next_pend = 1'b1;
            next_pend_data = next_pdata;
            next_pdata = parallel_data_o;
            next_pclk = 1'b0;
        end else if (emit) begin
            next_pclk = 1'b1;
        end else if (pend) begin
            next_pdata = pend_data;
            next_pclk = 1'b1;
        end else if (bit_stb && bitcnt == PCLK_FALL_BIT) begin
            next_pclk = 1'b0;
        end
        if (!rtn_s2) begin
            next_pend = 1'b0;
            next_aligned = 1'b0;
            next_cand_valid = 1'b0;
            next_xyz_cnt = 4'h0;
            next_pclk = 1'b0;
            next_pdata = 20'h00000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_raw <= 1'b0;
            scr <= 9'h000;
            vsr <= 30'h0000_0000;
            bitcnt <= 4'h0;
            trs_phase <= 4'h0;
            cand_phase <= 4'h0;
            cand_valid <= 1'b0;
            xyz_cnt <= 4'h0;
            aligned <= 1'b0;
            trs_seen <= 1'b0;
            idle_words <= 16'h0000;
            pair <= 1'b0;
            hold <= 10'h000;
            rd <= 1'b0;
            werr <= 1'b0;
            sync_seen <= 1'b0;
            pend <= 1'b0;
            pend_data <= 20'h00000;
            parallel_data_o <= 20'h00000;
            output_clock_o <= 1'b0;
            parallel_data_oe_o <= 1'b0;
            output_clock_oe_o <= 1'b0;
        end else begin
            prev_raw <= next_prev_raw;
            scr <= next_scr;
            vsr <= next_vsr;
            bitcnt <= next_bitcnt;
            trs_phase <= next_trs_phase;
            cand_phase <= next_cand_phase;
            cand_valid <= next_cand_valid;
            xyz_cnt <= next_xyz_cnt;
            aligned <= next_aligned;
            trs_seen <= next_trs_seen;
            idle_words <= next_idle_words;
            pair <= next_pair;
            hold <= next_hold;
            rd <= next_rd;
            werr <= next_werr;
            sync_seen <= next_sync_seen;
            pend <= next_pend;
            pend_data <= next_pend_data;
            parallel_data_o <= next_pdata;
            output_clock_o <= next_pclk;
            parallel_data_oe_o <= rtn_s2;
            output_clock_oe_o <= rtn_s2;
        end
    end
endmodule

// ---- sdiaf_checker.sv ----
// bound checker watching the ports of the descramble, align and output format block
`timescale 1ns/1ps
module sdiaf_checker #(
    parameter int unsigned TRS_TIMEOUT_WORDS = sdiaf_pkg::TRS_TIMEOUT_WORDS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [sdiaf_pkg::WB_AW-1:0] wb_adr_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic reset_test_n_i,
    input wire logic [19:0] parallel_data_o,
    input wire logic parallel_data_oe_o,
    input wire logic output_clock_o,
    input wire logic output_clock_oe_o
);
    import sdiaf_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged one cycle later");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held longer than one cycle");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("acknowledge without a request");
    unmapped_read_a: assert property (wb_ack_o && $past(wb_adr_i) != ADR_CTRL
        && $past(wb_adr_i) != ADR_STATUS |-> wb_dat_o == 32'h0)
        else $error("unmapped address returned nonzero data");
    reset_quiet_a: assert property ($fell(rst_i) |-> !wb_ack_o && !parallel_data_oe_o)
        else $error("outputs active straight after reset");
    oe_pair_a: assert property (parallel_data_oe_o == output_clock_oe_o)
        else $error("bus and clock enables differ");
    bus_float_a: assert property (!reset_test_n_i [*4] |-> !parallel_data_oe_o)
        else $error("outputs still driven in test reset");
    oe_rise_a: assert property ($rose(reset_test_n_i) |-> ##3 parallel_data_oe_o)
        else $error("outputs not driven three cycles after test reset");
    // a new word always comes with a fresh rising edge of the output clock
    word_clock_a: assert property (reset_test_n_i && parallel_data_oe_o
        && $changed(parallel_data_o) |-> $rose(output_clock_o))
        else $error("output word changed without a rising output clock");
    clock_hold_a: assert property ($rose(output_clock_o) |-> output_clock_o [*8])
        else $error("output clock high for under eight cycles");
endmodule
bind sdiaf_top sdiaf_checker #(.TRS_TIMEOUT_WORDS(TRS_TIMEOUT_WORDS)) chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .reset_test_n_i(reset_test_n_i), .parallel_data_o(parallel_data_o),
    .parallel_data_oe_o(parallel_data_oe_o), .output_clock_o(output_clock_o),
    .output_clock_oe_o(output_clock_oe_o)
);

// ---- sdiaf_capture_model.sv ----
// model of the downstream video processor capturing the parallel output bus
`timescale 1ns/1ps
module sdiaf_capture_model (
    input wire logic clk_i,
    input wire logic [19:0] bus_i,
    input wire logic pclk_i,
    output logic [79:0] hist_o
);
    logic pclk_q = 1'b0;
    initial hist_o = 80'h0;
    // newest word in the low 20 bits; a floating clock never counts as a rise
    always @(posedge clk_i) begin
        pclk_q <= pclk_i;
        if (pclk_i === 1'b1 && pclk_q !== 1'b1) begin
            hist_o <= {hist_o[59:0], bus_i};
        end
    end
endmodule

// ---- sdi_descramble_align_output_formatter_tb_top.sv ----
// self-checking testbench for the descramble, align and output format block
`timescale 1ns/1ps
module sdi_descramble_align_output_formatter_tb_top;
    import sdiaf_pkg::*;
    localparam int TIMEOUT_CYCLES = 70000;
    logic clk_i = 1'b0, rst_i = 1'b1;
    logic [WB_AW-1:0] wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'hF;
    logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic serial_clk_i = 1'b0, serial_data_i = 1'b0;
    logic reset_test_n_i = 1'b1, detected_rate_flag_i = 1'b0;
    logic [31:0] wb_dat_o, rdat;
    logic wb_ack_o, parallel_data_oe_o, output_clock_o, output_clock_oe_o;
    logic [19:0] parallel_data_o;
    logic [79:0] hist;
    logic [8:0] scr = 9'h0;
    logic nrzi = 1'b0;
    int num_errors = 0, check_count = 0, cycles = 0;
    wire [19:0] bus = parallel_data_oe_o ? parallel_data_o : 20'hZZZZZ;
    wire pclk = output_clock_oe_o ? output_clock_o : 1'bz;

    always #5 clk_i = ~clk_i;

    // short timeout keeps the loss-of-alignment run brief
    sdiaf_top #(.TRS_TIMEOUT_WORDS(64)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_clk_i(serial_clk_i),
        .serial_data_i(serial_data_i), .reset_test_n_i(reset_test_n_i),
        .detected_rate_flag_i(detected_rate_flag_i), .parallel_data_o(parallel_data_o),
        .parallel_data_oe_o(parallel_data_oe_o), .output_clock_o(output_clock_o),
        .output_clock_oe_o(output_clock_oe_o)
    );
    sdiaf_capture_model partner (.clk_i(clk_i), .bus_i(bus), .pclk_i(pclk), .hist_o(hist));

    task automatic results();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == TIMEOUT_CYCLES) begin
            num_errors++;
            $display("unexpected at %0t: run timed out", $time);
            results();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // entered just after a rising edge; ack is read before that edge's updates land
    task automatic wb_xfer(input logic [3:0] adr, input logic we, input logic [31:0] dat);
        wb_adr_i <= adr;
        wb_we_i <= we;
        wb_dat_i <= dat;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        // only the bench timeout ends a wait for an ack that never comes
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // data changes with the falling link clock so it is stable across the rising one
    task automatic send_bit(input logic b);
        serial_clk_i <= 1'b0;
        serial_data_i <= b;
        repeat (8) @(posedge clk_i);
        serial_clk_i <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask

    // video words go lsb first through scrambler and nrzi coder; raw words go msb first
    task automatic send_list(input logic [9:0] ws [$], input logic vid);
        logic b;
        foreach (ws[k]) begin
            for (int i = 0; i < 10; i++) begin
                b = vid ? ws[k][i] : ws[k][9 - i];
                if (vid) begin
                    b = b ^ scr[8] ^ scr[3];
                    scr = {scr[7:0], b};
                    nrzi = nrzi ^ b;
                    b = nrzi;
                end
                send_bit(b);
            end
        end
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb_xfer(ADR_CTRL, 1'b0, 32'h0);
        check(rdat, {27'h0, CTRL_RESET});
        wb_xfer(4'h8, 1'b1, 32'h1F);
        wb_xfer(4'h8, 1'b0, 32'h0);
        check(rdat, 32'h0);
        reset_test_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        check({30'h0, parallel_data_oe_o, output_clock_oe_o}, 32'h0);
        reset_test_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        check({30'h0, parallel_data_oe_o, output_clock_oe_o}, 32'h3);
        // data-through at 20 and 10 bits, and with both selects high
        for (int i = 0; i < 3; i++) begin
            wb_xfer(ADR_CTRL, 1'b1, (i == 0) ? 32'h8 : (i == 1) ? 32'h0 : 32'h6);
            repeat (6) send_list('{10'h3FF}, 1'b0);
            repeat (20) @(posedge clk_i);
            check({12'h0, hist[19:0]}, (i == 0) ? 32'hFFFFF : 32'hFFC00);
        end
        // manual video over both widths and rates, last pass with an eight-bit header
        for (int i = 0; i < 5; i++) begin
            wb_xfer(ADR_CTRL, 1'b1, {27'h0, i[1:0], 3'h2});
            repeat (4) send_list('{10'h200}, 1'b1);
            if (i == 4) send_list('{10'h3FC, 10'h003, 10'h002}, 1'b1);
            else send_list('{10'h3FF, 10'h000, 10'h000}, 1'b1);
            send_list('{10'h111, 10'h222, 10'h333}, 1'b1);
            repeat (20) @(posedge clk_i);
            check({12'h0, hist[19:0]}, {12'h0, 10'h333, i[0] ? 10'h222 : 10'h000});
            check({12'h0, hist[39:20]}, {12'h0, i[0] ? 10'h111 : 10'h222, 10'h000});
            wb_xfer(ADR_STATUS, 1'b0, 32'h0);
            check({30'h0, rdat[ST_RATE], rdat[ST_ALIGNED]}, {30'h0, i[1], 1'h1});
        end
        // auto: shift the bit phase; a lone sav must not move the boundary
        detected_rate_flag_i <= 1'b1;
        wb_xfer(ADR_CTRL, 1'b1, {27'h0, CTRL_RESET});
        repeat (3) send_bit(1'b0);
        send_list('{10'h200, 10'h200, 10'h3FF, 10'h000, 10'h000, 10'h200, 10'h155, 10'h155}, 1'b1);
        repeat (20) @(posedge clk_i);
        check_count++;
        if (hist[19:0] === 20'h55555) begin
            num_errors++;
            $display("unexpected at %0t: boundary moved without an eav", $time);
        end
        send_list('{10'h3FF, 10'h000, 10'h000, 10'h274, 10'h111, 10'h222}, 1'b1);
        repeat (20) @(posedge clk_i);
        check({12'h0, hist[19:0]}, {12'h0, 10'h222, 10'h111});
        check({22'h0, hist[39:30]}, {22'h0, 10'h274});
        wb_xfer(ADR_STATUS, 1'b0, 32'h0);
        check({31'h0, rdat[ST_RATE]}, 32'h1);
        detected_rate_flag_i <= 1'b0;
        repeat (140) send_list('{10'h200}, 1'b1);
        wb_xfer(ADR_STATUS, 1'b0, 32'h0);
        check({29'h0, rdat[ST_TRS], rdat[ST_RATE], rdat[ST_ALIGNED]}, 32'h0);
        // asi: commas of both disparities, two balanced bytes, then an illegal code
        wb_xfer(ADR_CTRL, 1'b1, 32'h4);
        send_list('{{K28_NEG, K28_5_NEG}, {K28_POS, K28_5_POS},
            {ASI_6B[3], ASI_4B[1]}, {ASI_6B[5], ASI_4B[2]}}, 1'b0);
        repeat (20) @(posedge clk_i);
        check({12'h0, hist[19:0]}, {12'h0, 2'h0, 8'h45, 10'h000});
        check({12'h0, hist[39:20]}, {12'h0, 2'h0, 8'h23, 10'h000});
        check({30'h0, hist[59:58]}, 32'h1);
        send_list('{10'h000}, 1'b0);
        repeat (20) @(posedge clk_i);
        check({31'h0, hist[19]}, 32'h1);
        wb_xfer(ADR_STATUS, 1'b0, 32'h0);
        check({30'h0, rdat[ST_SYNC], rdat[ST_WERR]}, 32'h1);
        results();
    end
endmodule
